//--- design/brps_top.v
// Operation
// - First phase drives address 7:2, oe/we levels, A17, raises latch enable.
// - Latch enable drops, then A15:8 and A16 driven, latch enable raised.
// - Byte read drives A1:A0, asserts chip enable, captures byte, releases enable.
// - Byte write drives A1:A0 and data under chip enable, then releases.
// - Expansion ROM read starts dword fetch; ready only after all steps.
// - Dword fetches bytes 3,2,1,0 with low lines 11,10,01,00.
// - Four bytes assembled into one word, driven with target ready.
// - ROM port covers 256KB with an 18-bit byte address.
// - Control bits 3..0 are serial data in, data out, clock, select while ROM select is clear.
`timescale 1ns/1ps
`include "brps_consts.vh"

module brps_top (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        exp_rd_req,
  input  wire [17:0] exp_rd_addr,
  output wire [31:0] exp_rd_data,
  output wire        exp_trdy,
  input  wire [7:0]  rom_muxed_data_lines_in,
  output wire [7:0]  rom_muxed_data_lines_out,
  output wire        rom_muxed_data_lines_oe,
  output wire [1:0]  rom_low_address_lines,
  output wire        rom_chip_enable_n,
  input  wire        srom_data_from_rom,
  output wire        srom_data_to_rom,
  output wire        srom_clk,
  output wire        srom_cs
);

  // ==========================================================
  // Constants and states
  // Byte is read through the pin synchroniser, so it shows the pins two clocks earlier
  localparam integer ACC_LAST_I = `BRPS_ACC_CYC - 1;
  localparam [3:0]   ACC_LAST   = ACC_LAST_I[3:0];
  // One-hot sequencer states
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_LAT1  = 6'h02;
  localparam [5:0] ST_LATLO = 6'h04;
  localparam [5:0] ST_LAT2  = 6'h08;
  localparam [5:0] ST_ACC   = 6'h10;
  localparam [5:0] ST_DONE  = 6'h20;

  // ==========================================================
  // Registers
  reg  [5:0]  state_ff;
  reg  [5:0]  nxt_state;
  reg  [3:0]  cnt_ff;
  reg  [1:0]  byte_ff;
  reg         is_wr_ff;
  reg         is_dw_ff;
  reg  [17:0] addr_ff;
  reg  [7:0]  data_ff;
  reg         rom_sel_ff;
  reg  [2:0]  srom_ff;
  reg  [17:0] offset_ff;
  reg  [31:0] word_ff;
  reg         trdy_ff;
  reg         ack_ff;
  reg  [31:0] rdata_ff;
  reg  [7:0]  rom_in_s1_ff;
  reg  [7:0]  rom_in_s2_ff;
  reg         sdin_s1_ff;
  reg         sdin_s2_ff;

  // ==========================================================
  // Request decode
  wire        busy       = (state_ff != ST_IDLE);
  wire        hit_ctrl   = (avs_address == `BRPS_CTRL_OFS);
  wire        hit_offset = (avs_address == `BRPS_OFFSET_OFS);
  wire        req        = avs_read | avs_write;
  // Control writes stall while a ROM cycle runs so a byte command cannot be lost;
  // a dword request pending in the same cycle stalls them too, otherwise a
  // byte command answered on that edge would find the sequencer busy and be lost
  wire        stall      = avs_write & hit_ctrl & (busy | (exp_rd_req & ~trdy_ff));
  wire        take       = req & ~ack_ff & ~stall;
  wire        wr_ctrl    = ack_ff & avs_write & hit_ctrl;
  wire        byte_rd    = wr_ctrl & avs_byteenable[1] &
                           avs_writedata[`BRPS_ROM_SEL_BIT] &
                           avs_writedata[`BRPS_RD_CMD_BIT];
  wire        byte_wr    = wr_ctrl & avs_byteenable[1] &
                           avs_writedata[`BRPS_ROM_SEL_BIT] &
                           avs_writedata[`BRPS_WR_CMD_BIT] &
                           ~avs_writedata[`BRPS_RD_CMD_BIT];
  wire        byte_start = byte_rd | byte_wr;
  // Byte command wins a tie; the requester just waits longer for ready
  // expansion ROM read starts a dword fetch
  wire        dw_start   = exp_rd_req & ~trdy_ff & ~byte_start;

  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata    = rdata_ff;

  // ==========================================================
  // Pin synchronisers
  // Two stages on every pin input; costs two clocks of ROM read latency
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rom_in_s1_ff <= 8'h00;
      rom_in_s2_ff <= 8'h00;
      sdin_s1_ff   <= 1'b0;
      sdin_s2_ff   <= 1'b0;
    end else begin
      rom_in_s1_ff <= rom_muxed_data_lines_in;
      rom_in_s2_ff <= rom_in_s1_ff;
      sdin_s1_ff   <= srom_data_from_rom;
      sdin_s2_ff   <= sdin_s1_ff;
    end
  end

  // ==========================================================
  // Register bus slave
  // Answer one clock after the request, except stalled control writes
  integer i;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff     <= 1'b0;
      rdata_ff   <= 32'h00000000;
      offset_ff  <= `BRPS_OFFSET_RST;
      rom_sel_ff <= 1'b0;
      srom_ff    <= 3'h0;
    end else begin
      ack_ff <= take;
      if (take && avs_read) begin
        if (hit_ctrl) begin
          rdata_ff <= 32'h00000000;
          rdata_ff[`BRPS_BUSY_BIT]    <= busy;
          rdata_ff[`BRPS_ROM_SEL_BIT] <= rom_sel_ff;
          // serial pins reflected in low bits, or the data byte while ROM select is set
          if (rom_sel_ff)
            rdata_ff[7:0] <= data_ff;
          else
            rdata_ff[7:0] <= {4'h0, sdin_s2_ff, srom_ff};
        end else if (hit_offset) begin
          rdata_ff <= {14'h0000, offset_ff};
        end else begin
          rdata_ff <= 32'h00000000;
        end
      end
      if (ack_ff && avs_write && hit_offset) begin
        for (i = 0; i < `BRPS_ADDR_W; i = i + 1) begin
          if (avs_byteenable[i/8])
            offset_ff[i] <= avs_writedata[i];
        end
      end
      if (wr_ctrl && avs_byteenable[1])
        rom_sel_ff <= avs_writedata[`BRPS_ROM_SEL_BIT];
      if (wr_ctrl && avs_byteenable[0] &&
          !(avs_byteenable[1] && avs_writedata[`BRPS_ROM_SEL_BIT]))
        srom_ff <= avs_writedata[2:0];
    end
  end

  // ==========================================================
  // ROM port sequencer
  // Latch phases take one clock each; the external latches are edge-triggered
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  if (byte_start || dw_start) nxt_state = ST_LAT1;
      ST_LAT1:  nxt_state = ST_LATLO;
      ST_LATLO: nxt_state = ST_LAT2;
      ST_LAT2:  nxt_state = ST_ACC;
      ST_ACC:   if (cnt_ff == ACC_LAST && (!is_dw_ff || byte_ff == 2'b00))
                  nxt_state = ST_DONE;
      ST_DONE:  nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= 4'h0;
      byte_ff  <= 2'b00;
      is_wr_ff <= 1'b0;
      is_dw_ff <= 1'b0;
      addr_ff  <= 18'h00000;
      data_ff  <= 8'h00;
      word_ff  <= 32'h00000000;
      trdy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      trdy_ff  <= 1'b0;
      if (wr_ctrl && avs_byteenable[0] && !busy)
        data_ff <= avs_writedata[7:0];
      if (state_ff == ST_IDLE) begin
        cnt_ff <= 4'h0;
        if (byte_start) begin
          addr_ff  <= offset_ff;
          is_wr_ff <= byte_wr;
          is_dw_ff <= 1'b0;
          byte_ff  <= offset_ff[1:0];
        end else if (dw_start) begin
          addr_ff  <= {exp_rd_addr[17:2], 2'b00};
          is_wr_ff <= 1'b0;
          is_dw_ff <= 1'b1;
          byte_ff  <= 2'b11;
        end
      end
      if (state_ff == ST_ACC) begin
        if (cnt_ff == ACC_LAST) begin
          cnt_ff <= 4'h0;
          if (is_dw_ff) begin
            // bytes placed by lane into one word
            word_ff[byte_ff*8 +: 8] <= rom_in_s2_ff;
            byte_ff <= byte_ff - 2'b01;
          end else if (!is_wr_ff) begin
            data_ff <= rom_in_s2_ff;
          end
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end
      // ready only once the word is complete
      if (state_ff == ST_DONE && is_dw_ff)
        trdy_ff <= 1'b1;
    end
  end

  // ==========================================================
  // ROM pin drive
  // Data pins driven only in latch phases and during a write access
  reg [7:0] bus_out;
  reg       bus_oe;
  reg [1:0] low_lines;
  reg       ce_n;
  // Latched control levels: read enables output, write enables write strobe
  wire      oe_lvl_n = is_wr_ff;
  wire      we_lvl_n = ~is_wr_ff;
  always @* begin
    bus_out   = 8'h00;
    bus_oe    = 1'b0;
    low_lines = 2'b00;
    ce_n      = 1'b1;
    case (state_ff)
      // first address group with latch enable high
      ST_LAT1: begin
        bus_out   = {addr_ff[7:2], oe_lvl_n, we_lvl_n};
        bus_oe    = 1'b1;
        low_lines = {1'b1, addr_ff[17]};
      end
      ST_LATLO: begin
        bus_out   = {addr_ff[7:2], oe_lvl_n, we_lvl_n};
        bus_oe    = 1'b1;
        low_lines = {1'b0, addr_ff[17]};
      end
      // second group shifts first into lower latch
      ST_LAT2: begin
        bus_out   = addr_ff[15:8];
        bus_oe    = 1'b1;
        low_lines = {1'b1, addr_ff[16]};
      end
      // Chip enable stays low across the four dword bytes
      // low lines and chip enable
      ST_ACC: begin
        low_lines = byte_ff;
        ce_n      = 1'b0;
        bus_out   = is_wr_ff ? data_ff : 8'h00;
        bus_oe    = is_wr_ff;
      end
      default: begin
        bus_out = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // Output wiring
  assign rom_muxed_data_lines_out = bus_out;
  assign rom_muxed_data_lines_oe  = bus_oe;
  assign rom_low_address_lines    = low_lines;
  assign rom_chip_enable_n        = ce_n;
  assign exp_rd_data              = word_ff;
  assign exp_trdy                 = trdy_ff;
  assign srom_data_to_rom         = srom_ff[2];
  assign srom_clk                 = srom_ff[1];
  assign srom_cs                  = srom_ff[0];

endmodule // brps_top

//--- design/brps_consts.vh
`ifndef BRPS_CONSTS_VH
`define BRPS_CONSTS_VH

// ==========================================================
// Register map (byte addresses on the register bus)
`define BRPS_CTRL_OFS      4'h0
`define BRPS_OFFSET_OFS    4'h4

// ==========================================================
// Control register fields
`define BRPS_RD_CMD_BIT    14
`define BRPS_WR_CMD_BIT    13
`define BRPS_ROM_SEL_BIT   12
`define BRPS_BUSY_BIT      31
`define BRPS_SDIN_BIT      3
`define BRPS_SDOUT_BIT     2
`define BRPS_SCLK_BIT      1
`define BRPS_SCS_BIT       0
`define BRPS_CTRL_RST      32'h00000000
`define BRPS_OFFSET_RST    18'h00000
`define BRPS_ADDR_W        18

// ==========================================================
// Timing
`define BRPS_CLK_NS        10
`define BRPS_ROM_ACC_NS    120
`define BRPS_ACC_CYC       ((`BRPS_ROM_ACC_NS + `BRPS_CLK_NS - 1) / `BRPS_CLK_NS)

`endif

//--- verif/brps_rom_model.sv
`timescale 1ns/1ps
// ==========================================
// Boot ROM behind two edge latches, serial ROM
module brps_rom_model #(
  parameter [15:0] SDAT = 16'hB36D
) (
  input  wire       sys_clk,
  input  wire [7:0] dq_o,
  input  wire       dq_oe,
  input  wire [1:0] la,
  input  wire       ce_n,
  output wire [7:0] dq_i,
  input  wire       sclk,
  input  wire       scs,
  output wire       sdo
);
  reg  [8:0]  up_l = 9'h000, lo_l = 9'h000;
  reg  [7:0]  mem [0:262143];
  reg  [17:0] wa;
  reg  [7:0]  wd;
  reg         wp = 1'h0, le_q = 1'h0;
  int         sc = 0;
  wire [7:0]  rom_q;
  wire [17:0] a = {lo_l[0], up_l[0], up_l[8:1], lo_l[8:3], la};
  initial for (int i = 0; i < 262144; i++) mem[i] = i[7:0] ^ i[15:8] ^ {6'h00, i[17:16]};
  assign #80 rom_q = (!ce_n && !lo_l[2]) ? mem[a] : ~mem[a];
  assign dq_i = dq_oe ? dq_o : rom_q;
  // latch pair, programming only clears bits
  always @(posedge sys_clk) begin
    le_q <= la[1];
    if (la[1] && !le_q && ce_n) begin
      lo_l <= up_l;
      up_l <= {dq_o, la[0]};
    end
    if (!ce_n && !lo_l[1]) begin
      wa <= a;
      wd <= dq_o;
      wp <= 1'h1;
    end else if (wp) begin
      mem[wa] <= mem[wa] & wd;
      wp <= 1'h0;
    end
  end
  // data follows command and six address clocks
  always @(posedge sclk or negedge scs) if (!scs) sc <= 0; else sc <= sc + 1;
  assign sdo = (scs && sc >= 10 && sc <= 25) ? SDAT[25 - sc] : ~SDAT[0];
endmodule // brps_rom_model

//--- verif/brps_top_asserts.sv
`timescale 1ns/1ps
// ==========================================
// Port checks for the boot ROM sequencer
module brps_checker (
  input wire        sys_clk,
  input wire        rstn,
  input wire [3:0]  avs_address,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire        avs_waitrequest,
  input wire        exp_rd_req,
  input wire        exp_trdy,
  input wire        rom_muxed_data_lines_oe,
  input wire [1:0]  rom_low_address_lines,
  input wire        rom_chip_enable_n,
  input wire        srom_data_to_rom,
  input wire        srom_clk,
  input wire        srom_cs
);
  wire le = rom_low_address_lines[1];
  wire cen = rom_chip_enable_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_trdy_pulse: assert property (exp_trdy |=> !exp_trdy) else $error("trdy too long");
  a_trdy_req: assert property (exp_trdy |-> exp_rd_req) else $error("trdy unasked");
  a_trdy_ce_off: assert property (exp_trdy |-> cen) else $error("enable on at trdy");
  a_latch_seq: assert property ($rose(le) && !$past(rom_muxed_data_lines_oe)
    |=> !le ##1 le ##1 !cen) else $error("latch order wrong");
  a_oe_latch: assert property ($rose(le) && cen |-> rom_muxed_data_lines_oe)
    else $error("address not driven");
  a_ce_len: assert property ($fell(cen) |-> !cen [*8]) else $error("enable too short");
  a_ce_after: assert property ($fell(cen) |-> $past(le)) else $error("enable before latch");
  a_byte_order: assert property (!cen && !$past(cen)
    && rom_low_address_lines != $past(rom_low_address_lines)
    |-> rom_low_address_lines == $past(rom_low_address_lines) - 2'h1) else $error("byte order");
  a_serial_map: assert property (avs_write && !avs_waitrequest && avs_address == 4'h0
    && !avs_writedata[12] |-> ##2 {srom_data_to_rom, srom_clk, srom_cs}
    == $past(avs_writedata[2:0], 2)) else $error("serial pins wrong");
  c_dword: cover property (exp_trdy);
  c_write: cover property ($fell(cen) && rom_muxed_data_lines_oe);
  c_sclk: cover property ($rose(srom_clk));
endmodule // brps_checker
bind brps_top brps_checker u_chk (.sys_clk, .rstn, .avs_address, .avs_write, .avs_writedata,
  .avs_waitrequest, .exp_rd_req, .exp_trdy, .rom_muxed_data_lines_oe, .rom_low_address_lines,
  .rom_chip_enable_n, .srom_data_to_rom, .srom_clk, .srom_cs);

//--- verif/tb_boot_rom_port_sequencer.sv
`timescale 1ns/1ps
`include "brps_consts.vh"
// ==========================================
// Bench for the boot ROM sequencer
module tb_boot_rom_port_sequencer;
  localparam [15:0] SDAT = 16'hB36D;
  reg          sys_clk = 1'h0, rstn = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  reg  [3:0]   avs_address = 4'h0, avs_byteenable = 4'h0;
  reg  [31:0]  avs_writedata = 32'h0, w, d;
  reg          exp_rd_req = 1'h0;
  reg  [17:0]  exp_rd_addr = 18'h0, a;
  wire [31:0]  avs_readdata, exp_rd_data;
  wire         avs_waitrequest, exp_trdy, rom_muxed_data_lines_oe, rom_chip_enable_n;
  wire [7:0]   rom_muxed_data_lines_in, rom_muxed_data_lines_out;
  wire [1:0]   rom_low_address_lines;
  wire         srom_data_from_rom, srom_data_to_rom, srom_clk, srom_cs;
  logic [63:0] q[$];
  int          n_fail = 0, compares = 0, i;
  brps_top u_dut (.sys_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .exp_rd_req, .exp_rd_addr, .exp_rd_data,
    .exp_trdy, .rom_muxed_data_lines_in, .rom_muxed_data_lines_out, .rom_muxed_data_lines_oe,
    .rom_low_address_lines, .rom_chip_enable_n, .srom_data_from_rom, .srom_data_to_rom,
    .srom_clk, .srom_cs);
  brps_rom_model #(.SDAT(SDAT)) u_rom (.sys_clk, .dq_o(rom_muxed_data_lines_out),
    .dq_oe(rom_muxed_data_lines_oe), .la(rom_low_address_lines), .ce_n(rom_chip_enable_n),
    .dq_i(rom_muxed_data_lines_in), .sclk(srom_clk), .scs(srom_cs), .sdo(srom_data_from_rom));
  function automatic [7:0] pat(input [17:0] x);
    pat = x[7:0] ^ x[15:8] ^ {6'h00, x[17:16]};
  endfunction
  function automatic [31:0] word(input [17:0] x);
    word = {pat({x[17:2], 2'h3}), pat({x[17:2], 2'h2}), pat({x[17:2], 2'h1}), pat({x[17:2], 2'h0})};
  endfunction
  task results;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task note(input [31:0] m, input [31:0] v);
    q.push_back({m, v & m});
  endtask
  task chk(input string nm, input [31:0] got);
    logic [63:0] e;
    e = 64'h0;
    if (q.size() == 0) begin
      n_fail++;
      $display("Error %s expected nothing seen %h", nm, got);
    end else e = q.pop_front();
    compares++;
    if ((got & e[63:32]) !== e[31:0]) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e[31:0], got & e[63:32]);
    end
  endtask
  // Request held until waitrequest is seen low
  task bus(input bit wr, input [3:0] ad, input [31:0] dt);
    int n;
    n = 0;
    @(posedge sys_clk);
    {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {!wr, wr, ad, dt, 4'hF};
    do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'h0 && n < 100);
    if (avs_waitrequest !== 1'h0) n_fail++;
    {avs_read, avs_write} <= 2'h0;
  endtask
  task xrd(input [17:0] ad);
    int n;
    n = 0;
    @(posedge sys_clk);
    {exp_rd_req, exp_rd_addr} <= {1'h1, ad};
    do begin @(posedge sys_clk); n++; end while (exp_trdy !== 1'h1 && n < 200);
    if (exp_trdy !== 1'h1) n_fail++;
    exp_rd_req <= 1'h0;
  endtask
  // Serial steps wait 25 clocks (250 ns) plus the bus access, just beyond the 250 ns minimum
  task sw(input [2:0] v);
    bus(1'h1, `BRPS_CTRL_OFS, {29'h0, v});
    repeat (25) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'h0) chk("readdata", avs_readdata);
    if (exp_trdy === 1'h1) chk("rom word", exp_rd_data);
  end
  initial forever #5 sys_clk = ~sys_clk;
  initial begin repeat (30000) @(posedge sys_clk); n_fail++; results; end
  initial begin
    void'($urandom(88));
    repeat (4) @(posedge sys_clk);
    rstn <= 1'h1;
    note(32'hFFFFFFF7, 32'h0);
    bus(1'h0, `BRPS_CTRL_OFS, 32'h0);
    note(32'hFFFFFFFF, 32'h0);
    bus(1'h0, 4'h8, 32'h0);
    $display("test reset and unmapped done");
    for (i = 0; i < 4; i++) begin
      a = (i == 0) ? 18'h3FFFF : 18'($urandom);
      bus(1'h1, `BRPS_OFFSET_OFS, {14'h0, a});
      bus(1'h1, `BRPS_CTRL_OFS, 32'h5000);
      note(32'h80000000, 32'h80000000);
      bus(1'h0, `BRPS_CTRL_OFS, 32'h0);
      repeat (20) @(posedge sys_clk);
      note(32'hFF, {24'h0, pat(a)});
      bus(1'h0, `BRPS_CTRL_OFS, 32'h0);
    end
    $display("test byte read done");
    for (i = 0; i < 4; i++) begin
      a = (i == 0) ? 18'h3FFFC : 18'($urandom);
      note(32'hFFFFFFFF, word(a));
      xrd(a);
    end
    a = 18'($urandom);
    w = $urandom;
    bus(1'h1, `BRPS_OFFSET_OFS, {14'h0, a});
    note(32'hFFFFFFFF, word(w[17:0]));
    fork
      xrd(w[17:0]);
      bus(1'h1, `BRPS_CTRL_OFS, 32'h5000);
    join
    repeat (20) @(posedge sys_clk);
    note(32'hFF, {24'h0, pat(a)});
    bus(1'h0, `BRPS_CTRL_OFS, 32'h0);
    $display("test dword read done");
    a = 18'($urandom);
    d = $urandom;
    bus(1'h1, `BRPS_OFFSET_OFS, {14'h0, a});
    bus(1'h1, `BRPS_CTRL_OFS, 32'h3000 | {24'h0, d[7:0]});
    bus(1'h1, `BRPS_CTRL_OFS, 32'h5000);
    repeat (20) @(posedge sys_clk);
    note(32'hFF, {24'h0, pat(a) & d[7:0]});
    bus(1'h0, `BRPS_CTRL_OFS, 32'h0);
    repeat (15) @(posedge sys_clk);
    w = word(a);
    w[8 * a[1:0] +: 8] = pat(a) & d[7:0];
    note(32'hFFFFFFFF, w);
    xrd(a);
    $display("test byte write done");
    sw(3'h0);
    sw(3'h1);
    for (i = 0; i < 9; i++) begin
      d[0] = (i < 3) ? (i < 2) : a[8 - i];
      sw({d[0], 2'h1});
      sw({d[0], 2'h3});
      sw({d[0], 2'h1});
    end
    for (i = 15; i >= 0; i--) begin
      sw(3'h3);
      note(32'h8, {28'h0, SDAT[i], 3'h0});
      bus(1'h0, `BRPS_CTRL_OFS, 32'h0);
      sw(3'h1);
    end
    sw(3'h0);
    $display("test serial read done");
    repeat (5) @(posedge sys_clk);
    if (q.size() != 0) n_fail++;
    results;
  end
endmodule // tb_boot_rom_port_sequencer
